// ### fault_mask_and_reset.sv
// Operation
// - unmasked comm status bit drives fault pin low
// - masked comm status never affects fault pin
// - mask b bit 6 gates nvm crc bits
// - mask b bit 5 gates other nvm bits
// - clear a bit 2 clears compare status
// - system clear bit clears status, self-clears
//
// The AXI4-Lite register port was decided locally.
module fault_mask_and_reset #(
   parameter int N_COMP = 4
) (
   // clock, reset, enable
   input  wire logic              core_clk_i,
   input  wire logic              arst_n_i,
   input  wire logic              clk_en_i,
   // axi4-lite write address
   input  wire logic [13:0]       s_axi_awaddr_i,
   input  wire logic              s_axi_awvalid_i,
   output logic                   s_axi_awready_o,
   // axi4-lite write data
   input  wire logic [31:0]       s_axi_wdata_i,
   input  wire logic [3:0]        s_axi_wstrb_i,
   input  wire logic              s_axi_wvalid_i,
   output logic                   s_axi_wready_o,
   // axi4-lite write response
   output logic [1:0]             s_axi_bresp_o,
   output logic                   s_axi_bvalid_o,
   input  wire logic              s_axi_bready_i,
   // axi4-lite read address
   input  wire logic [13:0]       s_axi_araddr_i,
   input  wire logic              s_axi_arvalid_i,
   output logic                   s_axi_arready_o,
   // axi4-lite read data
   output logic [31:0]            s_axi_rdata_o,
   output logic [1:0]             s_axi_rresp_o,
   output logic                   s_axi_rvalid_o,
   input  wire logic              s_axi_rready_i,
   // fault status from the detectors (same clock)
   input  wire logic [7:0]        group_any_i,
   input  wire logic [7:0]        comm_fault_status_i,
   input  wire logic [7:0]        nvm_fault_status_i,
   // per-group clear strobes to the status registers
   output logic [7:0]             group_clear_o,
   output logic                   comm_fault_clear_o,
   output logic                   nvm_crc_clear_o,
   output logic                   nvm_data_clear_o,
   output logic [N_COMP-1:0]      compare_fault_clear_o,
   // fault pin
   output logic                   fault_out_n_o
);

   // refuse clear widths the strobe logic cannot serve
   if (N_COMP < 1 || N_COMP > 32) begin : g_bad_n_comp
      $error("N_COMP out of range");
   end

   typedef enum logic [2:0] {
      WR_IDLE = 3'b001,
      WR_RESP = 3'b010,
      WR_HOLD = 3'b100
   } wr_state_t;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0]  mask_a_r;
   logic [7:0]  mask_b_r;
   logic [7:0]  clear_a_r;
   logic        fault_any;
   logic        fault_r;

   wr_state_t   wr_state_r;
   logic        aw_got_r;
   logic        w_got_r;
   logic [11:0] aw_idx_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        wr_fire;
   logic        wr_hit;
   logic        rd_hit;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   function automatic logic mapped(input logic [11:0] idx);
      if (idx == fault_pkg::IDX_GROUP_MASK_A) begin
         mapped = 1'b1;
      end else if (idx == fault_pkg::IDX_GROUP_MASK_B) begin
         mapped = 1'b1;
      end else if (idx == fault_pkg::IDX_GROUP_CLEAR_A) begin
         mapped = 1'b1;
      end else if (idx == fault_pkg::IDX_GROUP_CLEAR_B) begin
         mapped = 1'b1;
      end else if (idx == fault_pkg::IDX_FAULT_VIEW) begin
         mapped = 1'b1;
      end else begin
         mapped = 1'b0;
      end
   endfunction

   // ----------------------------------------------------------------
   // write channel
   // ----------------------------------------------------------------
   assign s_axi_awready_o = clk_en_i & (wr_state_r == WR_IDLE) & ~aw_got_r;
   assign s_axi_wready_o  = clk_en_i & (wr_state_r == WR_IDLE) & ~w_got_r;
   assign wr_fire         = clk_en_i & (wr_state_r == WR_IDLE) & aw_got_r & w_got_r;
   assign wr_hit          = mapped(aw_idx_r) & wstrb_r[0];

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         aw_got_r <= 1'b0;
         aw_idx_r <= 12'h000;
      end else if (clk_en_i) begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_got_r <= 1'b1;
            aw_idx_r <= s_axi_awaddr_i[fault_pkg::ADDR_W-1:fault_pkg::ADDR_LSB];
         end else if (wr_fire) begin
            aw_got_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         w_got_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else if (clk_en_i) begin
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata_i;
            wstrb_r <= s_axi_wstrb_i;
         end else if (wr_fire) begin
            w_got_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_state_r     <= WR_IDLE;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= fault_pkg::RESP_OKAY;
      end else if (clk_en_i) begin
         case (wr_state_r)
            WR_IDLE: begin
               if (wr_fire) begin
                  wr_state_r     <= WR_RESP;
                  s_axi_bvalid_o <= 1'b1;
                  s_axi_bresp_o  <= mapped(aw_idx_r) ? fault_pkg::RESP_OKAY : fault_pkg::RESP_SLVERR;
               end
            end
            WR_RESP: begin
               if (s_axi_bready_i) begin
                  s_axi_bvalid_o <= 1'b0;
                  wr_state_r     <= WR_HOLD;
               end
            end
            WR_HOLD: begin
               wr_state_r <= WR_IDLE;
            end
            default: begin
               wr_state_r <= WR_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // mask and clear registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mask_a_r <= fault_pkg::MASK_A_RESET;
         mask_b_r <= fault_pkg::MASK_B_RESET;
      end else if (clk_en_i && wr_fire && wr_hit) begin
         if (aw_idx_r == fault_pkg::IDX_GROUP_MASK_A) begin
            mask_a_r <= wdata_r[7:0];
         end else if (aw_idx_r == fault_pkg::IDX_GROUP_MASK_B) begin
            mask_b_r <= wdata_r[7:0];
         end
      end
   end

   // clear bits pulse one cycle: writing 0 does nothing, the self-clearing
   // bits read back 0 afterwards, the others hold what was written
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         clear_a_r             <= fault_pkg::CLEAR_A_RESET;
         group_clear_o         <= 8'h00;
         comm_fault_clear_o    <= 1'b0;
         nvm_crc_clear_o       <= 1'b0;
         nvm_data_clear_o      <= 1'b0;
         compare_fault_clear_o <= '0;
      end else if (clk_en_i) begin
         group_clear_o         <= 8'h00;
         comm_fault_clear_o    <= 1'b0;
         nvm_crc_clear_o       <= 1'b0;
         nvm_data_clear_o      <= 1'b0;
         compare_fault_clear_o <= '0;
         clear_a_r             <= clear_a_r & ~fault_pkg::CLEAR_A_SELF;
         if (wr_fire && wr_hit && aw_idx_r == fault_pkg::IDX_GROUP_CLEAR_A) begin
            clear_a_r     <= wdata_r[7:0] & ~fault_pkg::CLEAR_A_SELF;
            group_clear_o <= wdata_r[7:0];
            compare_fault_clear_o <= {N_COMP{wdata_r[fault_pkg::GRP_COMPARE]}};
         end else if (wr_fire && wr_hit && aw_idx_r == fault_pkg::IDX_GROUP_CLEAR_B) begin
            comm_fault_clear_o <= wdata_r[fault_pkg::MB_COMM];
            nvm_crc_clear_o    <= wdata_r[fault_pkg::MB_NVM_CRC];
            nvm_data_clear_o   <= wdata_r[fault_pkg::MB_NVM_DATA];
         end
      end
   end

   // ----------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------
   assign s_axi_arready_o = clk_en_i & ~s_axi_rvalid_o;
   assign rd_hit          = mapped(s_axi_araddr_i[fault_pkg::ADDR_W-1:fault_pkg::ADDR_LSB]);

   function automatic logic [7:0] rd_mux(input logic [11:0] idx, input logic [7:0] ma,
                                         input logic [7:0] mb, input logic [7:0] ca, input logic f);
      if (idx == fault_pkg::IDX_GROUP_MASK_A) begin
         rd_mux = ma;
      end else if (idx == fault_pkg::IDX_GROUP_MASK_B) begin
         rd_mux = mb;
      end else if (idx == fault_pkg::IDX_GROUP_CLEAR_A) begin
         rd_mux = ca;
      end else if (idx == fault_pkg::IDX_FAULT_VIEW) begin
         rd_mux = {7'h00, f};
      end else begin
         rd_mux = 8'h00;
      end
   endfunction

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o  <= 32'h0000_0000;
         s_axi_rresp_o  <= fault_pkg::RESP_OKAY;
      end else if (clk_en_i) begin
         if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o  <= rd_hit ? fault_pkg::RESP_OKAY : fault_pkg::RESP_SLVERR;
            s_axi_rdata_o  <= {24'h00_0000, rd_mux(s_axi_araddr_i[fault_pkg::ADDR_W-1:fault_pkg::ADDR_LSB],
                                                   mask_a_r, mask_b_r, clear_a_r, fault_r)};
         end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // fault pin
   // ----------------------------------------------------------------
   fault_gate #(
      .N (fault_pkg::NUM_GROUPS)
   ) u_gate (
      .group_any_i           (group_any_i),
      .group_gate_i          (mask_a_r),
      .comm_any_i            (|comm_fault_status_i),
      .comm_fault_gate_i     (mask_b_r[fault_pkg::MB_COMM]),
      .nvm_status_i          (nvm_fault_status_i),
      .nvm_crc_fault_gate_i  (mask_b_r[fault_pkg::MB_NVM_CRC]),
      .nvm_data_fault_gate_i (mask_b_r[fault_pkg::MB_NVM_DATA]),
      .fault_any_o           (fault_any)
   );

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fault_r <= 1'b0;
      end else if (clk_en_i) begin
         fault_r <= fault_any;
      end
   end

   assign fault_out_n_o = ~fault_r;

endmodule

// ### fault_pkg.sv
package fault_pkg;

   // ------------------------------------------------------------------
   // register map (printed offsets are not all multiples of four: indices)
   // ------------------------------------------------------------------
   localparam logic [11:0] IDX_GROUP_MASK_A  = 12'h016;
   localparam logic [11:0] IDX_GROUP_MASK_B  = 12'h017;
   localparam logic [11:0] IDX_GROUP_CLEAR_A = 12'h331;
   localparam logic [11:0] IDX_GROUP_CLEAR_B = 12'h332;
   localparam logic [11:0] IDX_FAULT_VIEW    = 12'h340;
   localparam int          ADDR_LSB          = 2;
   localparam int          ADDR_W            = 14;

   localparam logic [7:0]  MASK_A_RESET      = 8'h00;
   localparam logic [7:0]  MASK_B_RESET      = 8'h00;
   localparam logic [7:0]  CLEAR_A_RESET     = 8'h00;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int GRP_POWER       = 0;
   localparam int GRP_SYSTEM      = 1;
   localparam int GRP_COMPARE     = 2;
   localparam int GRP_OVERVOLT    = 3;
   localparam int GRP_UNDERVOLT   = 4;
   localparam int GRP_OVERTEMP    = 5;
   localparam int GRP_UNDERTEMP   = 6;
   localparam int GRP_PROTECTOR   = 7;
   localparam int NUM_GROUPS      = 8;

   localparam int MB_COMM         = 0;
   localparam int MB_NVM_DATA     = 5;
   localparam int MB_NVM_CRC      = 6;

   // bits of the nonvolatile fault register holding the two crc errors
   localparam logic [7:0] NVM_CRC_BITS = 8'h03;

   // bits of the first clear register that return to zero by themselves
   localparam logic [7:0] CLEAR_A_SELF = 8'h03;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### fault_gate.sv
module fault_gate #(
   parameter int N = 8
) (
   // status and gating
   input  wire logic [N-1:0] group_any_i,
   input  wire logic [N-1:0] group_gate_i,
   input  wire logic         comm_any_i,
   input  wire logic         comm_fault_gate_i,
   input  wire logic [7:0]   nvm_status_i,
   input  wire logic         nvm_crc_fault_gate_i,
   input  wire logic         nvm_data_fault_gate_i,
   // result
   output logic              fault_any_o
);
   if (N < 1) begin : g_bad_n
      $error("N out of range");
   end

   logic [N-1:0] group_hit;
   logic         nvm_crc_hit;
   logic         nvm_data_hit;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gen_grp
         assign group_hit[g] = group_any_i[g] & ~group_gate_i[g];
      end
   endgenerate

   assign nvm_crc_hit  = |(nvm_status_i & fault_pkg::NVM_CRC_BITS) & ~nvm_crc_fault_gate_i;
   assign nvm_data_hit = |(nvm_status_i & ~fault_pkg::NVM_CRC_BITS) & ~nvm_data_fault_gate_i;

   assign fault_any_o = (|group_hit) | (comm_any_i & ~comm_fault_gate_i) | nvm_crc_hit | nvm_data_hit;
endmodule

// ### fault_checker_properties.sv
module fault_checker #(
   parameter int N_COMP = 4
) (
   input wire logic              core_clk_i,
   input wire logic              arst_n_i,
   input wire logic              s_axi_arready_o,
   input wire logic              s_axi_bvalid_o,
   input wire logic              s_axi_bready_i,
   input wire logic              s_axi_rvalid_o,
   input wire logic              s_axi_rready_i,
   input wire logic [7:0]        group_any_i,
   input wire logic [7:0]        comm_fault_status_i,
   input wire logic [7:0]        nvm_fault_status_i,
   input wire logic [7:0]        group_clear_o,
   input wire logic [N_COMP-1:0] compare_fault_clear_o,
   input wire logic              fault_out_n_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic no_src;
   assign no_src = ~|{group_any_i, comm_fault_status_i, nvm_fault_status_i};
   default clocking dc @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);
   // ------
   // properties
   // ------
   a_pin_idle: assert property (no_src |=> fault_out_n_o)
      else $error("fault pin low without a source");
   a_comp_all: assert property (|compare_fault_clear_o |-> &compare_fault_clear_o)
      else $error("partial compare clear");
   a_comp_now: assert property (group_clear_o[2] |-> &compare_fault_clear_o)
      else $error("compare clear missing");
   a_comp_once: assert property (|compare_fault_clear_o |=> ~|compare_fault_clear_o)
      else $error("compare clear longer than one cycle");
   a_sys_once: assert property (group_clear_o[1] |=> !group_clear_o[1])
      else $error("system clear does not return to zero");
   a_clear_at_resp: assert property (|group_clear_o |-> $rose(s_axi_bvalid_o))
      else $error("clear pulse without write response");
   a_b_drop: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
      else $error("write response held after handshake");
   a_r_drop: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
      else $error("read data held after handshake");
   a_ar_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("read address accepted while data pending");
endmodule

// ### fault_host_model.sv
module fault_host_model (
   input wire logic core_clk_i,
   input wire logic fault_out_n_i,
   output logic     fault_seen_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // host samples the pin each cycle; low means a fault is reported
   always @(posedge core_clk_i) begin
      fault_seen_o <= !fault_out_n_i;
   end
endmodule

// ### tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [11:0] MA = fault_pkg::IDX_GROUP_MASK_A;
   localparam logic [11:0] MB = fault_pkg::IDX_GROUP_MASK_B;
   localparam logic [11:0] CA = fault_pkg::IDX_GROUP_CLEAR_A;
   localparam logic [1:0]  OK = fault_pkg::RESP_OKAY;
   localparam logic [1:0]  ER = fault_pkg::RESP_SLVERR;
   logic        core_clk_i = 1'b0, arst_n_i = 1'b0, clk_en_i = 1'b1;
   logic [13:0] s_axi_awaddr_i = 14'h0000, s_axi_araddr_i = 14'h0000;
   logic [31:0] s_axi_wdata_i = 32'h00000000, s_axi_rdata_o;
   logic [3:0]  s_axi_wstrb_i = 4'hF, compare_fault_clear_o;
   logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_arvalid_i = 1'b0;
   logic        s_axi_bready_i = 1'b0, s_axi_rready_i = 1'b0;
   logic [7:0]  group_any_i = 8'h00, comm_fault_status_i = 8'h00, nvm_fault_status_i = 8'h00;
   logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
   logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
   logic [7:0]  group_clear_o;
   logic        comm_fault_clear_o, nvm_crc_clear_o, nvm_data_clear_o, fault_out_n_o, fault_seen;
   int          bad_count = 0, num_checks = 0, cycles = 0, comp_pulses = 0, sys_pulses = 0, b_pulses = 0;
   logic [7:0]  last_clr = 8'h00;

   initial begin
      forever #25 core_clk_i = ~core_clk_i;
   end

   fault_mask_and_reset #(.N_COMP(4)) u_dut (.core_clk_i, .arst_n_i, .clk_en_i, .s_axi_awaddr_i,
      .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
      .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
      .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
      .s_axi_rready_i, .group_any_i, .comm_fault_status_i, .nvm_fault_status_i, .group_clear_o,
      .comm_fault_clear_o, .nvm_crc_clear_o, .nvm_data_clear_o, .compare_fault_clear_o, .fault_out_n_o);
   fault_host_model u_host (.core_clk_i, .fault_out_n_i(fault_out_n_o), .fault_seen_o(fault_seen));

   // ------
   // monitors, timeout and helpers
   // ------
   always @(posedge core_clk_i) begin
      if (&compare_fault_clear_o) comp_pulses <= comp_pulses + 1;
      if (group_clear_o[1]) sys_pulses <= sys_pulses + 1;
      if (comm_fault_clear_o & nvm_crc_clear_o & nvm_data_clear_o) b_pulses <= b_pulses + 1;
      if (|group_clear_o) last_clr <= group_clear_o;
   end

   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         test_done();
      end
   end

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic xfer(input logic is_wr, input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er);
      logic a, w, v;
      logic [31:0] dat;
      logic [1:0] rs;
      a = 1'b1;
      w = is_wr;
      v = 1'b0;
      if (is_wr) begin
         s_axi_awaddr_i <= {idx, 2'b00};
         s_axi_wdata_i <= {24'h000000, d};
      end else begin
         s_axi_araddr_i <= {idx, 2'b00};
      end
      while (!v) begin
         s_axi_awvalid_i <= a & is_wr;
         s_axi_wvalid_i <= w;
         s_axi_arvalid_i <= a & !is_wr;
         s_axi_bready_i <= is_wr;
         s_axi_rready_i <= !is_wr;
         @(negedge core_clk_i);
         if (is_wr ? s_axi_awready_o : s_axi_arready_o) a = 1'b0;
         if (s_axi_wready_o) w = 1'b0;
         v = is_wr ? s_axi_bvalid_o : s_axi_rvalid_o;
         dat = s_axi_rdata_o;
         rs = is_wr ? s_axi_bresp_o : s_axi_rresp_o;
         @(posedge core_clk_i);
      end
      chk("resp", {30'h00000000, rs}, {30'h00000000, er});
      if (!is_wr) chk("rdata", dat, {24'h000000, d});
   endtask

   // pin reaches the host two cycles after its cause
   task automatic pin(input logic e);
      repeat (3) @(posedge core_clk_i);
      chk("fault_seen", {31'h00000000, fault_seen}, {31'h00000000, e});
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge core_clk_i);
      arst_n_i <= 1'b1;
      @(posedge core_clk_i);
      xfer(0, MA, 8'h00, OK);
      xfer(0, MB, 8'h00, OK);
      xfer(0, CA, 8'h00, OK);
      xfer(1, 12'h3FF, 8'h5A, ER);
      xfer(0, 12'h3FF, 8'h00, ER);
      pin(1'b0);
      clk_en_i <= 1'b0;
      group_any_i <= 8'h01;
      pin(1'b0);
      clk_en_i <= 1'b1;
      pin(1'b1);
      group_any_i <= 8'h00;
      pin(1'b0);
      $display("done: reset and map");
      for (int g = 0; g < 8; g++) begin
         group_any_i <= 8'h01 << g;
         xfer(1, MA, ~(8'h01 << g), OK);
         pin(1'b1);
         xfer(1, MA, 8'h01 << g, OK);
         pin(1'b0);
         xfer(0, MA, 8'h01 << g, OK);
      end
      group_any_i <= 8'h00;
      xfer(1, MA, 8'h00, OK);
      $display("done: group gates");
      comm_fault_status_i <= 8'h80;
      pin(1'b1);
      xfer(0, fault_pkg::IDX_FAULT_VIEW, 8'h01, OK);
      xfer(1, MB, 8'h01, OK);
      pin(1'b0);
      comm_fault_status_i <= 8'h00;
      nvm_fault_status_i <= fault_pkg::NVM_CRC_BITS;
      xfer(1, MB, 8'h20, OK);
      pin(1'b1);
      xfer(1, MB, 8'h40, OK);
      pin(1'b0);
      nvm_fault_status_i <= ~fault_pkg::NVM_CRC_BITS;
      pin(1'b1);
      xfer(1, MB, 8'h20, OK);
      pin(1'b0);
      xfer(0, MB, 8'h20, OK);
      nvm_fault_status_i <= 8'h00;
      $display("done: comm and nvm gates");
      xfer(1, CA, 8'h04, OK);
      xfer(1, CA, 8'h00, OK);
      xfer(1, CA, 8'h06, OK);
      xfer(0, CA, 8'h04, OK);
      chk("compare clears", comp_pulses, 2);
      chk("system clears", sys_pulses, 1);
      chk("last group clear", {24'h000000, last_clr}, 32'h00000006);
      xfer(1, fault_pkg::IDX_GROUP_CLEAR_B, 8'h61, OK);
      xfer(0, fault_pkg::IDX_GROUP_CLEAR_B, 8'h00, OK);
      chk("comm and nvm clears", b_pulses, 1);
      $display("done: clears");
      xfer(1, MA, 8'hFF, OK);
      arst_n_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      arst_n_i <= 1'b1;
      @(posedge core_clk_i);
      xfer(0, MA, fault_pkg::MASK_A_RESET, OK);
      s_axi_wstrb_i <= 4'h0;
      xfer(1, MA, 8'h55, OK);
      s_axi_wstrb_i <= 4'hF;
      xfer(0, MA, fault_pkg::MASK_A_RESET, OK);
      $display("done: mid-run reset and strobe");
      test_done();
   end
endmodule

bind fault_mask_and_reset fault_checker #(.N_COMP(N_COMP)) u_chk (.core_clk_i, .arst_n_i, .s_axi_arready_o,
   .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_rvalid_o, .s_axi_rready_i, .group_any_i, .comm_fault_status_i,
   .nvm_fault_status_i, .group_clear_o, .compare_fault_clear_o, .fault_out_n_o);
